// [core/ccs_charge_ctrl.sv]
// Overview of operation
// - New cycle starts in precondition at 10% current until battery passes threshold.
// - Battery reaching precondition threshold moves precondition to fast-charge.
// - Precondition timer expiry before threshold enters time-out fault, charging stops.
// - Fast-charge regulates constant current; termination voltage moves to top-off.
// - Total timer expiry in fast-charge enters end-of-charge, restarts after 32ms.
// - Top-off regulates 4.20V; current taper moves to end-of-charge.
// - Total expiry in top-off enters end-of-charge, restarts on 205mV drop.
// - End-of-charge opens charge path, restarts when battery drops 205mV unless entered by fast-charge expiry.
// - Missing battery, input undervoltage or overvoltage forces suspend; clearing restarts.
// - Manual hold forces suspend; releasing it starts a fresh cycle.
// - Entry into end-of-charge raises charger event when both enables set.
// - Exit from end-of-charge raises charger event when both enables set.
// - End-of-charge indicator is one only in end-of-charge.
// - Charger event flag is set by its event, cleared by reading.
// - Phase code is 11 precondition, 01 charging, 10 end, 00 otherwise.
// - Precondition and total timeouts each have a two-bit select.
// - Safety timers stretch in proportion to reduced charge current.
// - Precondition expiry raises timer event when both enables set.
// - Total expiry raises timer event when both enables set.
// - Timer expired indicator shows that a timeout occurred.
// - Timer event flag is set by its event, cleared by reading.
// - Precondition select gives 40, 60, 80 minutes or disabled.
// - Total select gives 3, 4, 5 hours or disabled.
// - Charging indicator sinks in precondition, fast-charge, top-off; otherwise released.
`timescale 1ns/10ps
`default_nettype none
module ccs_charge_ctrl #(
  parameter int TICK_CYC  = ccs_pkg::TICK_CYC,
  parameter int MIN_TICKS = ccs_pkg::MIN_TICKS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  input  wire logic        bat_present_in,
  input  wire logic        input_uv_in,
  input  wire logic        input_ov_in,
  input  wire logic        bat_above_precond_in,
  input  wire logic        bat_at_term_in,
  input  wire logic        taper_reached_in,
  input  wire logic        bat_recharge_in,
  input  wire logic        current_reduced_in,
  input  wire logic [7:0]  current_frac_in,
  input  wire logic        manual_hold_in,
  input  wire logic [1:0]  precharge_timeout_select_in,
  input  wire logic [1:0]  total_timeout_select_in,
  input  wire logic        eoc_entry_irq_enable_in,
  input  wire logic        eoc_exit_irq_enable_in,
  input  wire logic        charger_event_enable_in,
  input  wire logic        precharge_expiry_irq_enable_in,
  input  wire logic        total_expiry_irq_enable_in,
  input  wire logic        timer_event_enable_in,
  input  wire logic        charger_event_read_in,
  input  wire logic        timer_event_read_in,
  output logic             charger_event_flag_out,
  output logic             timer_event_flag_out,
  output logic             irq_out,
  output logic             eoc_state_indicator_out,
  output logic             timer_expired_indicator_out,
  output logic [1:0]       charge_phase_code_out,
  output logic             charging_indicator_out,
  output logic             charging_indicator_oe_out,
  output logic             charge_path_en_out,
  output logic             cc_mode_out,
  output logic             cv_mode_out,
  output logic [6:0]       current_pct_out,
  output logic [12:0]      cv_target_mv_out
);
  import ccs_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  ccs_tmr_if tmr_bus ();

  ccs_state_t  state_r, state_nxt;
  logic        relax_r, relax_nxt;
  logic [5:0]  relax_cnt_r, relax_cnt_nxt;
  logic        tmr_ind_r, tmr_ind_nxt;
  logic        phase_ok;
  logic [1:0]  phase_r, phase_nxt;
  logic        eoc_ind_r, eoc_ind_nxt;
  logic        oe_r, oe_nxt;
  logic        path_r, path_nxt;
  logic        cc_r, cc_nxt;
  logic        cv_r, cv_nxt;
  logic [6:0]  pct_r, pct_nxt;
  logic [12:0] cvt_r, cvt_nxt;
  logic        suspend_req, relax_done, eoc_entry, eoc_exit, fired;
  logic [1:0]  evt_set, evt_read, evt_flag;
  logic        evt_irq;

  // ****************************************
  // Safety timers
  // ****************************************
  assign tmr_bus.ce       = clk_en_in;
  assign tmr_bus.restart  = (state_nxt == CCS_PRECOND) && (state_r != CCS_PRECOND);
  assign tmr_bus.run_pre  = (state_r == CCS_PRECOND);
  assign tmr_bus.run_tot  = (state_r == CCS_FAST) || (state_r == CCS_TOPOFF);
  assign tmr_bus.pre_sel  = precharge_timeout_select_in;
  assign tmr_bus.tot_sel  = total_timeout_select_in;
  assign tmr_bus.reduced  = current_reduced_in;
  assign tmr_bus.cur_frac = current_frac_in;

  ccs_safety_timer #(
    .TICK_CYC  (TICK_CYC),
    .MIN_TICKS (MIN_TICKS)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .t          (tmr_bus.tmr)
  );

  // ****************************************
  // Charge state machine
  // ****************************************
  always_comb begin
    suspend_req = !bat_present_in || input_uv_in || input_ov_in || manual_hold_in;
    relax_done  = relax_r && tmr_bus.ms_tick && (relax_cnt_r == RELAX_MS - 6'h1);
    state_nxt     = state_r;
    relax_nxt     = relax_r;
    relax_cnt_nxt = (relax_r && tmr_bus.ms_tick) ? relax_cnt_r + 6'h1 : relax_cnt_r;
    if (suspend_req) begin
      state_nxt = CCS_SUSPEND;
    end else begin
      unique case (state_r)
        CCS_SUSPEND: begin
          state_nxt = CCS_PRECOND;
        end
        CCS_PRECOND: begin
          if (bat_above_precond_in) begin
            state_nxt = CCS_FAST;
          end else if (tmr_bus.pre_exp) begin
            state_nxt = CCS_FAULT;
          end
        end
        CCS_FAST: begin
          if (bat_at_term_in) begin
            state_nxt = CCS_TOPOFF;
          end else if (tmr_bus.tot_exp) begin
            state_nxt = CCS_EOC;
            relax_nxt = 1'b1;
          end
        end
        CCS_TOPOFF: begin
          if (taper_reached_in || tmr_bus.tot_exp) begin
            state_nxt = CCS_EOC;
          end
        end
        CCS_EOC: begin
          if (relax_done || (!relax_r && bat_recharge_in)) begin
            state_nxt = CCS_PRECOND;
          end
        end
        CCS_FAULT: begin
          state_nxt = CCS_FAULT;
        end
      endcase
    end
    if (state_nxt != CCS_EOC || state_r != CCS_EOC) begin
      relax_cnt_nxt = 6'h0;
    end
    if (state_nxt != CCS_EOC) begin
      relax_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r     <= STATE_RST;
      relax_r     <= 1'b0;
      relax_cnt_r <= 6'h0;
    end else if (clk_en_in) begin
      state_r     <= state_nxt;
      relax_r     <= relax_nxt;
      relax_cnt_r <= relax_cnt_nxt;
    end
  end

  // ****************************************
  // Events and indicators
  // ****************************************
  // A flag only counts an event in a cycle that really advances the state
  always_comb begin
    eoc_entry = clk_en_in && (state_nxt == CCS_EOC) && (state_r != CCS_EOC);
    eoc_exit  = clk_en_in && (state_nxt != CCS_EOC) && (state_r == CCS_EOC);
    evt_set[0] = charger_event_enable_in
                 && ((eoc_entry && eoc_entry_irq_enable_in)
                 || (eoc_exit && eoc_exit_irq_enable_in));
    evt_set[1] = timer_event_enable_in && clk_en_in
                 && ((tmr_bus.pre_exp && precharge_expiry_irq_enable_in)
                 || (tmr_bus.tot_exp && total_expiry_irq_enable_in));
    evt_read = {timer_event_read_in, charger_event_read_in};
    fired = tmr_bus.pre_exp || tmr_bus.tot_exp;
    if (fired) begin
      tmr_ind_nxt = 1'b1;
    end else if (tmr_bus.restart) begin
      tmr_ind_nxt = 1'b0;
    end else begin
      tmr_ind_nxt = tmr_ind_r;
    end
  end

  ccs_event_flags u_flags (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .clk_en_in  (clk_en_in),
    .set_in     (evt_set),
    .read_in    (evt_read),
    .flag_out   (evt_flag),
    .irq_out    (evt_irq)
  );

  // ****************************************
  // Regulation commands
  // ****************************************
  // Outputs follow the next state so they line up with state_r
  always_comb begin
    eoc_ind_nxt = (state_nxt == CCS_EOC);
    oe_nxt      = ccs_is_charging(state_nxt);
    path_nxt    = ccs_is_charging(state_nxt);
    cc_nxt      = (state_nxt == CCS_PRECOND) || (state_nxt == CCS_FAST);
    cv_nxt      = (state_nxt == CCS_TOPOFF);
    cvt_nxt     = CV_TARGET_MV;
    pct_nxt     = PCT_OFF;
    phase_nxt   = PH_IDLE;
    unique case (state_nxt)
      CCS_PRECOND: begin
        pct_nxt   = PCT_PRECOND;
        phase_nxt = PH_PRECOND;
      end
      CCS_FAST, CCS_TOPOFF: begin
        pct_nxt   = PCT_FAST;
        phase_nxt = PH_CHARGE;
      end
      CCS_EOC: begin
        phase_nxt = PH_EOC;
      end
      CCS_SUSPEND, CCS_FAULT: begin
        phase_nxt = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr_ind_r <= 1'b0;
      phase_r   <= PH_IDLE;
      eoc_ind_r <= 1'b0;
      oe_r      <= 1'b0;
      path_r    <= 1'b0;
      cc_r      <= 1'b0;
      cv_r      <= 1'b0;
      pct_r     <= PCT_OFF;
      cvt_r     <= CV_TARGET_MV;
    end else if (clk_en_in) begin
      tmr_ind_r <= tmr_ind_nxt;
      phase_r   <= phase_nxt;
      eoc_ind_r <= eoc_ind_nxt;
      oe_r      <= oe_nxt;
      path_r    <= path_nxt;
      cc_r      <= cc_nxt;
      cv_r      <= cv_nxt;
      pct_r     <= pct_nxt;
      cvt_r     <= cvt_nxt;
    end
  end

  // Open-drain pin only ever sinks, so the level is a fixed low
  assign charging_indicator_out      = 1'b0;
  assign charging_indicator_oe_out   = oe_r;
  assign charger_event_flag_out      = evt_flag[0];
  assign timer_event_flag_out        = evt_flag[1];
  assign irq_out                     = evt_irq;
  assign eoc_state_indicator_out     = eoc_ind_r;
  assign timer_expired_indicator_out = tmr_ind_r;
  assign charge_phase_code_out       = phase_r;
  assign charge_path_en_out          = path_r;
  assign cc_mode_out                 = cc_r;
  assign cv_mode_out                 = cv_r;
  assign current_pct_out             = pct_r;
  assign cv_target_mv_out            = cvt_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  assign phase_ok = (state_r == CCS_PRECOND) ? (phase_r == 2'h3) : 1'b1;

  a_precond_current: assert property (state_r == CCS_PRECOND |-> current_pct_out == PCT_PRECOND)
    else $error("precondition current wrong");
  a_precond_advance: assert property (state_r == CCS_PRECOND && !suspend_req && bat_above_precond_in
    && clk_en_in |=> state_r == CCS_FAST)
    else $error("precondition did not advance");
  a_precond_fault: assert property (state_r == CCS_PRECOND && !suspend_req && !bat_above_precond_in
    && tmr_bus.pre_exp && clk_en_in |=> state_r == CCS_FAULT && !charge_path_en_out)
    else $error("precondition timeout did not fault");
  a_fast_topoff: assert property (state_r == CCS_FAST && !suspend_req && bat_at_term_in
    && clk_en_in |=> state_r == CCS_TOPOFF ##0 cv_mode_out)
    else $error("fast-charge did not reach top-off");
  a_relax_restart: assert property (state_r == CCS_EOC && !suspend_req && relax_done
    && clk_en_in |=> state_r == CCS_PRECOND)
    else $error("relax restart missing");
  a_topoff_cv: assert property (state_r == CCS_TOPOFF |-> cv_mode_out && cv_target_mv_out == CV_TARGET_MV)
    else $error("top-off not constant voltage");
  a_eoc_path_off: assert property (state_r == CCS_EOC |-> !charge_path_en_out && eoc_state_indicator_out)
    else $error("end-of-charge path not open");
  a_suspend_entry: assert property (suspend_req && clk_en_in |=> state_r == CCS_SUSPEND
    ##1 (state_r == CCS_SUSPEND || !clk_en_in || !$past(suspend_req) || state_r == CCS_PRECOND))
    else $error("suspend not entered");
  a_fault_hold: assert property (state_r == CCS_FAULT && !suspend_req |=> state_r == CCS_FAULT)
    else $error("fault left without suspend");
  a_phase_code: assert property (phase_ok && (state_r != CCS_EOC || phase_r == 2'h2))
    else $error("phase code wrong");
  a_charging_pin: assert property (charging_indicator_oe_out == ccs_is_charging(state_r))
    else $error("charging indicator mismatch");
  a_timer_ind: assert property (fired && clk_en_in |=> timer_expired_indicator_out)
    else $error("timer indicator not set");
  a_eoc_event: assert property (eoc_entry && eoc_entry_irq_enable_in && charger_event_enable_in
    |=> charger_event_flag_out && irq_out)
    else $error("eoc entry event missing");

  c_full_cycle: cover property (state_r == CCS_TOPOFF ##1 state_r == CCS_EOC);
  c_fault: cover property (state_r == CCS_PRECOND ##1 state_r == CCS_FAULT);
  c_relax: cover property (relax_done);
  c_suspend: cover property (state_r == CCS_FAST ##1 state_r == CCS_SUSPEND);
endmodule
`default_nettype wire

// [core/ccs_event_flags.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_event_flags (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic [1:0] set_in,
  input  wire logic [1:0] read_in,
  output logic      [1:0] flag_out,
  output logic            irq_out
);
  logic [1:0] flag_r, flag_nxt;
  logic       irq_r, irq_nxt;

  // Set wins over the read so an event in the read cycle is kept
  for (genvar i = 0; i < 2; i++) begin : g_flag
    assign flag_nxt[i] = set_in[i] | (flag_r[i] & ~read_in[i]);
  end

  always_comb begin
    irq_nxt = |flag_nxt;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_r <= 2'h0;
      irq_r  <= 1'b0;
    end else if (clk_en_in) begin
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign flag_out = flag_r;
  assign irq_out  = irq_r;

  a_set_wins_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    set_in[0] && read_in[0] && clk_en_in |=> flag_out[0])
    else $error("charger flag lost on read");
  a_read_clears: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    read_in[1] && !set_in[1] && clk_en_in |=> !flag_out[1])
    else $error("timer flag not cleared by read");
  a_irq_follows: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    irq_out == |flag_out)
    else $error("interrupt does not match flags");
endmodule
`default_nettype wire

// [core/ccs_pkg.sv]
package ccs_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int MIN_TICKS     = 60000;
  localparam logic [5:0] RELAX_MS = 6'h20;

  // ****************************************
  // Timeout selections in minutes
  // ****************************************
  localparam logic [1:0] SEL_OFF      = 2'h3;
  localparam logic [8:0] PRE_MIN_SEL0 = 9'h028;
  localparam logic [8:0] PRE_MIN_SEL1 = 9'h03c;
  localparam logic [8:0] PRE_MIN_SEL2 = 9'h050;
  localparam logic [8:0] TOT_MIN_SEL0 = 9'h0b4;
  localparam logic [8:0] TOT_MIN_SEL1 = 9'h0f0;
  localparam logic [8:0] TOT_MIN_SEL2 = 9'h12c;
  localparam logic [8:0] MIN_SAT      = 9'h1ff;
  localparam logic [8:0] RATE_FULL    = 9'h100;

  // ****************************************
  // Regulation commands and phase codes
  // ****************************************
  localparam logic [6:0]  PCT_PRECOND  = 7'h0a;
  localparam logic [6:0]  PCT_FAST     = 7'h64;
  localparam logic [6:0]  PCT_OFF      = 7'h00;
  localparam logic [12:0] CV_TARGET_MV = 13'h1068;
  localparam logic [1:0]  PH_PRECOND   = 2'h3;
  localparam logic [1:0]  PH_CHARGE    = 2'h1;
  localparam logic [1:0]  PH_EOC       = 2'h2;
  localparam logic [1:0]  PH_IDLE      = 2'h0;

  typedef enum logic [2:0] {
    CCS_SUSPEND, CCS_PRECOND, CCS_FAST, CCS_TOPOFF, CCS_EOC, CCS_FAULT
  } ccs_state_t;
  localparam ccs_state_t STATE_RST = CCS_SUSPEND;

  function automatic logic [8:0] ccs_pre_limit(input logic [1:0] sel);
    return (sel == 2'h0) ? PRE_MIN_SEL0 : (sel == 2'h1) ? PRE_MIN_SEL1 : PRE_MIN_SEL2;
  endfunction

  function automatic logic [8:0] ccs_tot_limit(input logic [1:0] sel);
    return (sel == 2'h0) ? TOT_MIN_SEL0 : (sel == 2'h1) ? TOT_MIN_SEL1 : TOT_MIN_SEL2;
  endfunction

  function automatic logic ccs_is_charging(input ccs_state_t s);
    return (s == CCS_PRECOND) || (s == CCS_FAST) || (s == CCS_TOPOFF);
  endfunction
endpackage

// [core/ccs_safety_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_safety_timer #(
  parameter int TICK_CYC  = 100000,
  parameter int MIN_TICKS = 60000
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  ccs_tmr_if.tmr   t
);
  import ccs_pkg::*;

  logic [16:0] tick_r, tick_nxt;
  logic [15:0] msc_r, msc_nxt;
  logic [7:0]  acc_r, acc_nxt;
  logic [8:0]  min_r, min_nxt;
  logic        pre_done_r, pre_done_nxt;
  logic        tot_done_r, tot_done_nxt;
  logic [8:0]  acc_sum;
  logic        tick, eff_ms, min_end;

  // Reduced current slows the stretched millisecond proportionally
  always_comb begin
    tick    = (tick_r == 17'(TICK_CYC - 1));
    acc_sum = {1'b0, acc_r} + (t.reduced ? {1'b0, t.cur_frac} : RATE_FULL);
    eff_ms  = tick && acc_sum[8];
    min_end = eff_ms && (msc_r == 16'(MIN_TICKS - 1));
    t.pre_exp = t.run_pre && (t.pre_sel != SEL_OFF) && !pre_done_r
                && (min_r >= ccs_pre_limit(t.pre_sel));
    t.tot_exp = t.run_tot && (t.tot_sel != SEL_OFF) && !tot_done_r
                && (min_r >= ccs_tot_limit(t.tot_sel));
    t.ms_tick = tick;
    tick_nxt     = tick ? 17'h0 : tick_r + 17'h1;
    acc_nxt      = tick ? acc_sum[7:0] : acc_r;
    msc_nxt      = min_end ? 16'h0 : (eff_ms ? msc_r + 16'h1 : msc_r);
    min_nxt      = (min_end && min_r != MIN_SAT) ? min_r + 9'h1 : min_r;
    pre_done_nxt = pre_done_r || t.pre_exp;
    tot_done_nxt = tot_done_r || t.tot_exp;
    if (t.restart) begin
      tick_nxt     = 17'h0;
      acc_nxt      = 8'h0;
      msc_nxt      = 16'h0;
      min_nxt      = 9'h0;
      pre_done_nxt = 1'b0;
      tot_done_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_r     <= 17'h0;
      acc_r      <= 8'h0;
      msc_r      <= 16'h0;
      min_r      <= 9'h0;
      pre_done_r <= 1'b0;
      tot_done_r <= 1'b0;
    end else if (t.ce) begin
      tick_r     <= tick_nxt;
      acc_r      <= acc_nxt;
      msc_r      <= msc_nxt;
      min_r      <= min_nxt;
      pre_done_r <= pre_done_nxt;
      tot_done_r <= tot_done_nxt;
    end
  end

  a_pre_once: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    t.pre_exp && t.ce && !t.restart |=> !t.pre_exp)
    else $error("precondition expiry repeated");
endmodule
`default_nettype wire

// [core/ccs_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ccs_tmr_if;
  logic       ce;
  logic       restart;
  logic       run_pre;
  logic       run_tot;
  logic [1:0] pre_sel;
  logic [1:0] tot_sel;
  logic       reduced;
  logic [7:0] cur_frac;
  logic       ms_tick;
  logic       pre_exp;
  logic       tot_exp;
  modport ctrl (output ce, restart, run_pre, run_tot, pre_sel, tot_sel, reduced, cur_frac,
                input ms_tick, pre_exp, tot_exp);
  modport tmr  (input ce, restart, run_pre, run_tot, pre_sel, tot_sel, reduced, cur_frac,
                output ms_tick, pre_exp, tot_exp);
endinterface
`default_nettype wire

// [testbench/ccs_bat_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Cell comparators from a voltage in mV
// ****************************************
module ccs_bat_model #(
  parameter int PRE_MV  = 3000,
  parameter int TERM_MV = 4200,
  parameter int DROP_MV = 205
) (
  input  wire logic [12:0] mv_in,
  output logic             above_precond_out,
  output logic             at_term_out,
  output logic             recharge_out
);
  assign above_precond_out = (mv_in >= PRE_MV);
  assign at_term_out       = (mv_in >= TERM_MV);
  assign recharge_out      = (mv_in <= TERM_MV - DROP_MV);
endmodule
`default_nettype wire

// [testbench/charge_cycle_state_controller_test.sv]
`timescale 1ns/10ps
`default_nettype none
module charge_cycle_state_controller_test;
  import ccs_pkg::*;
  localparam int TK = 4;
  localparam int MT = 2;
  logic clk = 0, nrst = 0, uv = 0, hold = 0, taper = 0, crd = 0, trd = 0;
  logic ce = 1'h1, bp = 1'h1, ov = 1'h0, red = 1'h0;
  logic [1:0] psel = 2'h0, tsel = 2'h0;
  logic [5:0] en = 6'h3f;
  logic [12:0] mv = 13'h09c4;
  logic [31:0] lf = 32'hbde4;
  logic [7:0] frac = 8'h00;
  logic ap, at, rc, cf, tf, irq, eoc, tex, ci, oe, path, cc, cv;
  logic [1:0] ph;
  logic [6:0] pct;
  logic [12:0] cvt;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Random fraction while reduction is off; a fixed half rate keeps the stretched timeout exact
  always @(posedge clk) begin
    lf <= lfsr_next(lf);
    frac <= red ? 8'h80 : lf[7:0];
  end
  ccs_bat_model u_bat (.mv_in(mv), .above_precond_out(ap), .at_term_out(at), .recharge_out(rc));
  ccs_charge_ctrl #(.TICK_CYC(TK), .MIN_TICKS(MT)) u_dut (
    .ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(ce), .bat_present_in(bp), .input_uv_in(uv),
    .input_ov_in(ov), .bat_above_precond_in(ap), .bat_at_term_in(at), .taper_reached_in(taper),
    .bat_recharge_in(rc), .current_reduced_in(red), .current_frac_in(frac), .manual_hold_in(hold),
    .precharge_timeout_select_in(psel), .total_timeout_select_in(tsel), .eoc_entry_irq_enable_in(en[0]),
    .eoc_exit_irq_enable_in(en[1]), .charger_event_enable_in(en[2]), .precharge_expiry_irq_enable_in(en[3]),
    .total_expiry_irq_enable_in(en[4]), .timer_event_enable_in(en[5]), .charger_event_read_in(crd),
    .timer_event_read_in(trd), .charger_event_flag_out(cf), .timer_event_flag_out(tf), .irq_out(irq),
    .eoc_state_indicator_out(eoc), .timer_expired_indicator_out(tex), .charge_phase_code_out(ph),
    .charging_indicator_out(ci), .charging_indicator_oe_out(oe), .charge_path_en_out(path),
    .cc_mode_out(cc), .cv_mode_out(cv), .current_pct_out(pct), .cv_target_mv_out(cvt));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Expected outputs of a phase, worked out from the phase alone
  task automatic state(logic [1:0] p);
    chk("phase", p, ph);
    chk("oe", (p == PH_PRECOND || p == PH_CHARGE), oe);
    chk("pct", (p == PH_PRECOND) ? PCT_PRECOND : (p == PH_CHARGE) ? PCT_FAST : PCT_OFF, pct);
    chk("eoc", p == PH_EOC, eoc);
    chk("path", (p == PH_PRECOND || p == PH_CHARGE), path);
  endtask
  task automatic rd();
    @(posedge clk) begin crd <= 1; trd <= 1; end
    @(posedge clk) begin crd <= 0; trd <= 0; end
    cyc(3);
    chk("cflag", 1'b0, cf);
    chk("tflag", 1'b0, tf);
    chk("irq", 1'b0, irq);
  endtask
  task automatic wait_ph(logic [1:0] p, bit eq, output int k);
    k = 0;
    while (((ph === p) != eq) && k < 4000) begin
      cyc(1);
      k++;
    end
    if (k >= 4000) begin
      num_errors++;
      test_done();
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    cyc(2);
    state(PH_PRECOND);
    chk("cc", 1'b1, cc);
    chk("ci", 1'b0, ci);
    @(posedge clk) mv <= 13'h0dac;
    cyc(2);
    state(PH_CHARGE);
    @(posedge clk) mv <= 13'h1068;
    cyc(2);
    chk("cv", 1'b1, cv);
    chk("cvt", CV_TARGET_MV, cvt);
    @(posedge clk) taper <= 1;
    cyc(3);
    state(PH_EOC);
    chk("cflag", 1'b1, cf);
    chk("irq", 1'b1, irq);
    rd();
    @(posedge clk) begin taper <= 0; mv <= 13'h0f96; end
    cyc(3);
    chk("eoc", 1'b0, eoc);
    chk("cflag", 1'b1, cf);
    rd();
    @(posedge clk) begin mv <= 13'h09c4; hold <= 1; end
    cyc(2);
    state(PH_IDLE);
    @(posedge clk) hold <= 0;
    wait_ph(PH_PRECOND, 1'b1, n);
    wait_ph(PH_IDLE, 1'b1, n);
    chk("pre_to_lo", 1'b1, n >= 40 * MT * TK - 2);
    chk("pre_to_hi", 1'b1, n <= 40 * MT * TK + 20);
    cyc(2);
    state(PH_IDLE);
    chk("tex", 1'b1, tex);
    chk("tflag", 1'b1, tf);
    rd();
    @(posedge clk) uv <= 1;
    cyc(2);
    state(PH_IDLE);
    @(posedge clk) uv <= 0;
    cyc(2);
    state(PH_PRECOND);
    chk("tex", 1'b0, tex);
    @(posedge clk) mv <= 13'h0dac;
    wait_ph(PH_EOC, 1'b1, n);
    chk("tot_to_lo", 1'b1, n >= 180 * MT * TK - 20);
    chk("tot_to_hi", 1'b1, n <= 180 * MT * TK + 20);
    cyc(3);
    chk("tflag", 1'b1, tf);
    wait_ph(PH_EOC, 1'b0, n);
    chk("relax_lo", 1'b1, n >= 32 * TK - 6);
    chk("relax_hi", 1'b1, n <= 32 * TK + 6);
    @(posedge clk) begin bp <= 0; mv <= 13'h09c4; red <= 1; psel <= 2'h1; end
    cyc(2);
    state(PH_IDLE);
    @(posedge clk) begin bp <= 1; ov <= 1; end
    cyc(2);
    state(PH_IDLE);
    @(posedge clk) ov <= 0;
    wait_ph(PH_PRECOND, 1'b1, n);
    wait_ph(PH_IDLE, 1'b1, n);
    chk("stretch_lo", 1'b1, n >= 120 * MT * TK - 2);
    chk("stretch_hi", 1'b1, n <= 120 * MT * TK + 20);
    @(posedge clk) ce <= 0;
    @(posedge clk) hold <= 1;
    @(posedge clk) hold <= 0;
    cyc(3);
    chk("frozen", 1'b1, tex);
    @(posedge clk) ce <= 1;
    test_done();
  end
endmodule
`default_nettype wire
